// File: design/ssrc_map.svh
// Constants of the supply supervisor and reset control block.
// Assumes a 250 MHz system clock and the plain register port of the top.
// Notes on behaviour
// - Hold system reset while supply below threshold
// - Start option load at release threshold
// - Option load confirms, changes or disables brownout
// - Five brownout levels chosen by option bytes
// - With brownout at power-on, release at 1.8 V
// - Optional reference shutdown during Stop mode
// - Seven software-selected detector threshold levels
// - Detector interrupt on fall, rise or both
// - Detector silent until software enables it
// - Start-up 3.3 ms with brownout, else 1 ms
`ifndef SSRC_MAP_SVH
`define SSRC_MAP_SVH

// Register offsets on the 3-bit address port
`define SSRC_ADDR_CTRL 3'h0
`define SSRC_ADDR_STATUS 3'h1
`define SSRC_ADDR_CLEAR 3'h2
`define SSRC_ADDR_IRQ_EN 3'h3

// Control register fields
`define SSRC_CTRL_DET_EN 0
`define SSRC_CTRL_LVL_LO 1
`define SSRC_CTRL_LVL_HI 3
`define SSRC_CTRL_FALL_EN 4
`define SSRC_CTRL_RISE_EN 5
`define SSRC_CTRL_REF_OFF 6

// Status, clear and enable layout
`define SSRC_EV_FALL 0
`define SSRC_EV_RISE 1
`define SSRC_ST_DET_ABOVE 2
`define SSRC_ST_BOR_ON 3
`define SSRC_ST_BOR_LO 4
`define SSRC_ST_BOR_HI 6
`define SSRC_ST_RUN 7

// Reset values
`define SSRC_CTRL_RST 8'h00
`define SSRC_IRQ_EN_RST 2'h0

// Level ranges: five brownout levels, seven detector levels
`define SSRC_BOR_LVL_MAX 3'h4
`define SSRC_BOR_LVL_DEF 3'h0
`define SSRC_DET_LVL_MAX 3'h6

// Start-up times in microseconds and clock period in ns
`define SSRC_CLK_PERIOD_NS 4
`define SSRC_TSTART_BOR_US 3300
`define SSRC_TSTART_NOBOR_US 1000
`define SSRC_TSTART_BOR_CYC (`SSRC_TSTART_BOR_US * 1000 / `SSRC_CLK_PERIOD_NS)
`define SSRC_TSTART_NOBOR_CYC (`SSRC_TSTART_NOBOR_US * 1000 / `SSRC_CLK_PERIOD_NS)

`endif

// File: design/ssrc_pkg.sv
// Types of the supply supervisor and reset control block.
// Assumes the constants header is compiled alongside.
package ssrc_pkg;

    // Sequencer states from power-on to normal run
    typedef enum logic [1:0] {
        SSRC_HOLD,
        SSRC_START,
        SSRC_OPTLOAD,
        SSRC_RUN
    } ssrc_state_t;

endpackage : ssrc_pkg

// File: design/ssrc_supervisor.sv
// Supply supervisor digital control: reset sequencer, option load,
// brownout level selection and the programmable voltage detector.
// Assumes comparator outputs and option storage answers are synchronous
// to clk, except the detector output which is synchronised here.
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "ssrc_map.svh"

module ssrc_supervisor #(
    parameter int unsigned START_BOR_CYC = `SSRC_TSTART_BOR_CYC,
    parameter int unsigned START_NOBOR_CYC = `SSRC_TSTART_NOBOR_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    // Supply comparators
    input wire logic supplyAbovePor,
    input wire logic supplyAboveBrownout,
    input wire logic brownoutAtPowerUp,
    input wire logic detectorAbove,
    input wire logic stopMode,
    // Option byte storage
    input wire logic optValid,
    input wire logic optBrownoutOff,
    input wire logic [2:0] optBrownoutLevel,
    output logic optLoadReq,
    // Register port
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    // Controls to the analog side and the system
    output logic systemReset,
    output logic brownoutEnable,
    output logic [2:0] brownoutThresholdLevel,
    output logic detectorEnable,
    output logic [2:0] detectorThresholdLevel,
    output logic referenceOff,
    output logic irq
);

    // Clamp a level code to the highest legal code
    function automatic logic [2:0] clampLevel(input logic [2:0] lvl, input logic [2:0] maxLvl);
        clampLevel = (lvl > maxLvl) ? maxLvl : lvl;
    endfunction : clampLevel

    // Sequencer state
    ssrc_pkg::ssrc_state_t state_q;
    ssrc_pkg::ssrc_state_t state_d;
    logic [19:0] startCnt_q; // Start-up delay counter
    logic [19:0] startCnt_d;
    logic borPowerUp_q; // Strap caught after reset release
    logic borPowerUp_d;
    logic strapTaken_q; // Strap caught once
    logic strapTaken_d;
    logic borOn_q; // Brownout detection in force
    logic borOn_d;
    logic [2:0] borLvl_q; // Brownout level in force
    logic [2:0] borLvl_d;
    logic sysRst_q; // System reset output
    logic sysRst_d;
    logic optReq_q; // Option load request
    logic optReq_d;
    logic supplyOk; // Supply above the active threshold

    // Detector path
    logic detMeta_q; // First synchroniser stage
    logic detSync_q; // Second synchroniser stage
    logic [2:0] detWarm_q; // Ones shift in as the synchroniser fills after reset
    logic detPrev_q; // Previous synchronised level
    logic detPrev_d;
    logic [7:0] ctrl_q; // Control register
    logic [7:0] ctrl_d;
    logic [1:0] pend_q; // Sticky event flags
    logic [1:0] pend_d;
    logic [1:0] irqEn_q; // Interrupt enables
    logic [1:0] irqEn_d;
    logic [1:0] evt; // Crossing events this cycle
    logic [7:0] rdData_q;
    logic [7:0] rdData_d;
    logic irq_q;
    logic irq_d;
    logic refOff_q;
    logic refOff_d;

    // Active threshold: brownout comparator when enabled, else power-on level
    // Before the strap is caught borOn_q is 0, so the power-on level rules
    always_comb begin
        supplyOk = borOn_q ? supplyAboveBrownout : supplyAbovePor;
    end

    // Sequencer next state
    always_comb begin
        state_d = state_q;
        startCnt_d = startCnt_q;
        borPowerUp_d = borPowerUp_q;
        strapTaken_d = 1'b1;
        borOn_d = borOn_q;
        borLvl_d = borLvl_q;
        optReq_d = 1'b0;
        if (!strapTaken_q) begin
            // Strap sampled on the first edge after release
            // A later strap change is ignored until the next reset
            borPowerUp_d = brownoutAtPowerUp;
            borOn_d = brownoutAtPowerUp;
        end
        case (state_q)
            ssrc_pkg::SSRC_HOLD: begin
                // Held until supply crosses the release threshold
                // Cleared here so every re-entry restarts the full delay
                startCnt_d = 20'h00000;
                if (strapTaken_q && supplyOk) begin
                    state_d = ssrc_pkg::SSRC_START;
                end
            end
            ssrc_pkg::SSRC_START: begin
                // Start-up delay, longer with brownout at power-up
                // 20 bits hold the long default count with room to spare
                if (!supplyOk) begin
                    state_d = ssrc_pkg::SSRC_HOLD;
                end else if (borPowerUp_q ?
                        (startCnt_q >= 20'(START_BOR_CYC - 1)) :
                        (startCnt_q >= 20'(START_NOBOR_CYC - 1))) begin
                    state_d = ssrc_pkg::SSRC_OPTLOAD;
                    optReq_d = 1'b1;
                end else begin
                    startCnt_d = startCnt_q + 20'h00001;
                end
            end
            ssrc_pkg::SSRC_OPTLOAD: begin
                // Option load: confirm, change or disable brownout
                // Slow option storage only stretches the request, never drops it
                optReq_d = 1'b1;
                if (!supplyOk) begin
                    state_d = ssrc_pkg::SSRC_HOLD;
                    optReq_d = 1'b0;
                end else if (optValid) begin
                    optReq_d = 1'b0;
                    state_d = ssrc_pkg::SSRC_RUN;
                    borOn_d = !optBrownoutOff;
                    borLvl_d = clampLevel(optBrownoutLevel, `SSRC_BOR_LVL_MAX);
                end
            end
            ssrc_pkg::SSRC_RUN: begin
                // Supply drop below the active threshold resets the system
                // Option results stay in force until the next load
                if (!supplyOk) begin
                    state_d = ssrc_pkg::SSRC_HOLD;
                end
            end
            default: begin
                state_d = ssrc_pkg::SSRC_HOLD;
            end
        endcase
        // Reset stays asserted everywhere except run
        sysRst_d = (state_d != ssrc_pkg::SSRC_RUN);
    end

    // Sequencer registers
    // Reset output powers up asserted so the system never runs early
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ssrc_pkg::SSRC_HOLD;
            startCnt_q <= 20'h00000;
            borPowerUp_q <= 1'b0;
            strapTaken_q <= 1'b0;
            borOn_q <= 1'b0;
            borLvl_q <= `SSRC_BOR_LVL_DEF;
            sysRst_q <= 1'b1;
            optReq_q <= 1'b0;
        end else begin
            state_q <= state_d;
            startCnt_q <= startCnt_d;
            borPowerUp_q <= borPowerUp_d;
            strapTaken_q <= strapTaken_d;
            borOn_q <= borOn_d;
            borLvl_q <= borLvl_d;
            sysRst_q <= sysRst_d;
            optReq_q <= optReq_d;
        end
    end

    // Detector synchroniser; only the second stage is read
    // Warm-up bits count the first three edges after reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            detMeta_q <= 1'b0;
            detSync_q <= 1'b0;
            detWarm_q <= 3'h0;
        end else begin
            detMeta_q <= detectorAbove;
            detSync_q <= detMeta_q;
            detWarm_q <= {detWarm_q[1:0], 1'b1};
        end
    end

    // Edge detection and register file next values
    // Status is built from registered state only, never half-updated
    always_comb begin
        // Previous level tracks while disabled so enabling makes no edge
        detPrev_d = detSync_q;
        evt = 2'h0;
        // Edges ignored until both stages and the previous level hold
        // real samples: the reset zeros would otherwise look like a rise
        if (ctrl_q[`SSRC_CTRL_DET_EN] && detWarm_q[2]) begin
            evt[`SSRC_EV_FALL] = detPrev_q && !detSync_q
                && ctrl_q[`SSRC_CTRL_FALL_EN];
            evt[`SSRC_EV_RISE] = !detPrev_q && detSync_q
                && ctrl_q[`SSRC_CTRL_RISE_EN];
        end
        ctrl_d = ctrl_q;
        irqEn_d = irqEn_q;
        pend_d = pend_q;
        // Software writes
        if (regWrEn) begin
            case (regAddr)
                `SSRC_ADDR_CTRL: begin
                    ctrl_d = regWrData;
                    ctrl_d[`SSRC_CTRL_LVL_HI:`SSRC_CTRL_LVL_LO] = clampLevel(
                        regWrData[`SSRC_CTRL_LVL_HI:`SSRC_CTRL_LVL_LO],
                        `SSRC_DET_LVL_MAX);
                    ctrl_d[7] = 1'b0;
                end
                `SSRC_ADDR_CLEAR: begin
                    // Ones clear, zeros leave the other flag alone
                    pend_d = pend_q & ~regWrData[1:0];
                end
                `SSRC_ADDR_IRQ_EN: begin
                    irqEn_d = regWrData[1:0];
                end
                default: begin
                    // Status is read-only, others unmapped
                end
            endcase
        end
        // A new event wins over a clear in the same cycle
        pend_d = pend_d | evt;
        // Read data stands the cycle after the strobe only
        // Zero outside the answer cycle keeps a shared read bus quiet
        rdData_d = 8'h00;
        if (regRdEn) begin
            case (regAddr)
                `SSRC_ADDR_CTRL: begin
                    rdData_d = ctrl_q;
                end
                `SSRC_ADDR_STATUS: begin
                    rdData_d[1:0] = pend_q;
                    rdData_d[`SSRC_ST_DET_ABOVE] = detSync_q;
                    rdData_d[`SSRC_ST_BOR_ON] = borOn_q;
                    rdData_d[`SSRC_ST_BOR_HI:`SSRC_ST_BOR_LO] = borLvl_q;
                    rdData_d[`SSRC_ST_RUN] = (state_q == ssrc_pkg::SSRC_RUN);
                end
                `SSRC_ADDR_IRQ_EN: begin
                    rdData_d[1:0] = irqEn_q;
                end
                default: begin
                    rdData_d = 8'h00;
                end
            endcase
        end
        // Level interrupt from enabled pending flags
        // Built from next values so irq moves on the flag's own edge
        irq_d = |(pend_d & irqEn_d);
        // Reference shutdown only in Stop mode and when asked for
        // Limitation: the reference is cut whatever the sequencer state
        refOff_d = ctrl_d[`SSRC_CTRL_REF_OFF] && stopMode;
    end

    // Register file and output registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            detPrev_q <= 1'b0;
            ctrl_q <= `SSRC_CTRL_RST;
            pend_q <= 2'h0;
            irqEn_q <= `SSRC_IRQ_EN_RST;
            rdData_q <= 8'h00;
            irq_q <= 1'b0;
            refOff_q <= 1'b0;
        end else begin
            detPrev_q <= detPrev_d;
            ctrl_q <= ctrl_d;
            pend_q <= pend_d;
            irqEn_q <= irqEn_d;
            rdData_q <= rdData_d;
            irq_q <= irq_d;
            refOff_q <= refOff_d;
        end
    end

    // Outputs straight from flip-flops
    // Levels are clamped on the way in, so readback shows what is in force
    assign optLoadReq = optReq_q;
    assign regRdData = rdData_q;
    assign systemReset = sysRst_q;
    assign brownoutEnable = borOn_q;
    assign brownoutThresholdLevel = borLvl_q;
    assign detectorEnable = ctrl_q[`SSRC_CTRL_DET_EN];
    assign detectorThresholdLevel = ctrl_q[`SSRC_CTRL_LVL_HI:`SSRC_CTRL_LVL_LO];
    assign referenceOff = refOff_q;
    assign irq = irq_q;

endmodule : ssrc_supervisor
`default_nettype wire

// File: verification/ssrc_supervisor_sva.sv
// Port checker for the supply supervisor, bound into every instance.
// Assumes one clock domain; sys_rst is asynchronous and active high.
`timescale 1ns/1ns
`default_nettype none
module ssrc_supervisor_chk #(
    parameter int unsigned START_BOR_CYC = 20,
    parameter int unsigned START_NOBOR_CYC = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic supplyAbovePor,
    input wire logic supplyAboveBrownout,
    input wire logic brownoutAtPowerUp,
    input wire logic detectorAbove,
    input wire logic stopMode,
    input wire logic optValid,
    input wire logic optBrownoutOff,
    input wire logic [2:0] optBrownoutLevel,
    input wire logic optLoadReq,
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic systemReset,
    input wire logic brownoutEnable,
    input wire logic [2:0] brownoutThresholdLevel,
    input wire logic detectorEnable,
    input wire logic [2:0] detectorThresholdLevel,
    input wire logic referenceOff,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Option answer taken while the supply is good
    sequence s_optTaken;
        optLoadReq && optValid && supplyAbovePor && supplyAboveBrownout;
    endsequence
    chk_reset_supply_low: assert property (
        !supplyAbovePor && !supplyAboveBrownout |=> systemReset) else $error("no reset");
    chk_load_in_reset: assert property (
        optLoadReq |-> systemReset) else $error("load outside reset");
    chk_release_on_load: assert property (
        s_optTaken |=> !systemReset && !optLoadReq) else $error("no release");
    chk_bor_enable_opt: assert property (
        s_optTaken |=> brownoutEnable == !$past(optBrownoutOff)) else $error("bor enable");
    chk_bor_level_opt: assert property (s_optTaken |=> brownoutThresholdLevel ==
        ($past(optBrownoutLevel) > 3'h4 ? 3'h4 : $past(optBrownoutLevel))) else $error("bor lvl");
    chk_bor_held_pre: assert property (
        systemReset && brownoutEnable && !supplyAboveBrownout |=> !optLoadReq)
        else $error("early load");
    chk_ref_off_stop: assert property (
        !$past(stopMode) |-> !referenceOff) else $error("ref off outside stop");
    chk_det_config: assert property (regWrEn && regAddr == 3'h0 |=>
        detectorThresholdLevel == ($past(regWrData[3:1]) > 3'h6 ? 3'h6 : $past(regWrData[3:1]))
        && detectorEnable == $past(regWrData[0])) else $error("det config");
    chk_irq_needs_det: assert property (
        $rose(irq) && !$past(regWrEn && regAddr == 3'h3) |-> $past(detectorEnable))
        else $error("irq while off");
endmodule : ssrc_supervisor_chk
bind ssrc_supervisor ssrc_supervisor_chk #(.START_BOR_CYC(START_BOR_CYC),
    .START_NOBOR_CYC(START_NOBOR_CYC)) u_chk (.clk, .sys_rst, .supplyAbovePor,
    .supplyAboveBrownout, .brownoutAtPowerUp, .detectorAbove, .stopMode, .optValid,
    .optBrownoutOff, .optBrownoutLevel, .optLoadReq, .regAddr, .regWrData, .regWrEn,
    .regRdEn, .regRdData, .systemReset, .brownoutEnable, .brownoutThresholdLevel,
    .detectorEnable, .detectorThresholdLevel, .referenceOff, .irq);
`default_nettype wire

// File: verification/ssrc_supply_model.sv
// Far side model: supply comparators and option storage.
// Assumes the shared clk; the bench sets supply state and option values.
`timescale 1ns/1ns
`default_nettype none
module ssrc_supply_model #(
    parameter int LAT = 3 // Storage read latency in cycles
) (
    input wire logic clk,
    input wire logic porOk,
    input wire logic borOk,
    input wire logic cfgOff,
    input wire logic [2:0] cfgLvl,
    input wire logic optLoadReq,
    output logic supplyAbovePor,
    output logic supplyAboveBrownout,
    output var logic optValid = 1'b0,
    output logic optBrownoutOff,
    output logic [2:0] optBrownoutLevel
);
    int cnt = 0; // Cycles since the request rose
    // Comparators mirror the bench's supply picture
    assign supplyAbovePor = porOk;
    assign supplyAboveBrownout = borOk;
    // One answer per request, after LAT cycles
    always @(posedge clk) begin
        cnt <= optLoadReq ? cnt + 1 : 0;
        optValid <= optLoadReq && (cnt == LAT - 1);
    end
    // Data is scrambled outside the valid cycle, so stale values never pass
    assign optBrownoutOff = optValid ? cfgOff : ~cfgOff;
    assign optBrownoutLevel = optValid ? cfgLvl : ~cfgLvl;
endmodule : ssrc_supply_model
`default_nettype wire

// File: verification/tb.sv
// Bench for the supply supervisor: power-up table, detector events, registers.
// Assumes the design package, header and the far side model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam int NB = 20; // Short start-up counts keep the run brief
    localparam int NN = 8;
    logic clk = 1'b0, sys_rst = 1'b1, brownoutAtPowerUp = 1'b0, detectorAbove = 1'b1;
    logic stopMode = 1'b0, porOk = 1'b0, borOk = 1'b0, cfgOff = 1'b0;
    logic regWrEn = 1'b0, regRdEn = 1'b0;
    logic [2:0] cfgLvl = 3'h0, regAddr = 3'h0, optBrownoutLevel;
    logic [2:0] brownoutThresholdLevel, detectorThresholdLevel;
    logic [7:0] regWrData = 8'h00, regRdData;
    logic supplyAbovePor, supplyAboveBrownout, optValid, optBrownoutOff, optLoadReq;
    logic systemReset, brownoutEnable, detectorEnable, referenceOff, irq;
    int numErrors = 0, numChecks = 0;
    always #2 clk = ~clk; // 250 MHz
    ssrc_supervisor #(.START_BOR_CYC(NB), .START_NOBOR_CYC(NN)) u_ssrc_supervisor (.clk,
        .sys_rst, .supplyAbovePor, .supplyAboveBrownout, .brownoutAtPowerUp, .detectorAbove,
        .stopMode, .optValid, .optBrownoutOff, .optBrownoutLevel, .optLoadReq, .regAddr,
        .regWrData, .regWrEn, .regRdEn, .regRdData, .systemReset, .brownoutEnable,
        .brownoutThresholdLevel, .detectorEnable, .detectorThresholdLevel, .referenceOff, .irq);
    ssrc_supply_model u_ssrc_supply_model (.clk, .porOk, .borOk, .cfgOff, .cfgLvl,
        .optLoadReq, .supplyAbovePor, .supplyAboveBrownout, .optValid, .optBrownoutOff,
        .optBrownoutLevel);
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        numChecks++;
        if (s !== e) begin
            numErrors++;
            $display("[ERR] %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d errors %0d", numChecks, numErrors);
        if (numErrors == 0 && numChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    // A wait that used its bound ends the run
    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            numErrors++;
            final_report();
        end
    endtask : bound
    // Land just after an edge, where outputs are settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrEn <= 1'b0;
        #1;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e,
        input string n);
        @(posedge clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        chk(n, regRdData & m, e);
    endtask : rd
    // Power cycle with option set i: odd i has the strap, i 2 disables brownout
    task automatic pwr(input int i);
        int n;
        int t;
        logic [2:0] el;
        n = 0;
        t = i[0] ? NB : NN;
        el = (i > 4) ? 3'h4 : 3'(i);
        sys_rst <= 1'b1;
        porOk <= 1'b0;
        borOk <= 1'b0;
        brownoutAtPowerUp <= i[0];
        cfgOff <= (i == 2);
        cfgLvl <= 3'(i);
        cyc(6);
        chk("rstHeld", {7'h00, systemReset}, 8'h01);
        sys_rst <= 1'b0;
        porOk <= 1'b1;
        if (i[0]) begin
            cyc(30);
            chk("borHold", {6'h00, systemReset, optLoadReq}, 8'h02);
        end
        borOk <= 1'b1;
        while (!optLoadReq && n < 99) begin
            cyc(1);
            n++;
        end
        bound(n, 99);
        chk("startLen", {7'h00, n >= t && n <= t + 4}, 8'h01);
        n = 0;
        while (systemReset && n < 20) begin
            cyc(1);
            n++;
        end
        bound(n, 20);
        chk("borEn", {7'h00, brownoutEnable}, {7'h00, i != 2});
        chk("borLvl", {5'h00, brownoutThresholdLevel}, {5'h00, el});
        rd(3'h1, 8'hf8, {1'b1, el, i != 2, 3'h0}, "status");
        $display("power-up case %0d done", i);
    endtask : pwr
    initial begin
        for (int i = 0; i < 6; i++) begin
            pwr(i);
        end
        rd(3'h0, 8'hff, 8'h00, "ctrlRst");
        porOk <= 1'b0;
        borOk <= 1'b0;
        cyc(2);
        chk("dropRst", {7'h00, systemReset}, 8'h01);
        pwr(4);
        detectorAbove <= 1'b0;
        cyc(6);
        rd(3'h1, 8'h03, 8'h00, "detOff");
        detectorAbove <= 1'b1;
        wr(3'h0, 8'h1f);
        rd(3'h0, 8'hff, 8'h1d, "ctrl");
        wr(3'h3, 8'h03);
        cyc(6);
        chk("noEdge", {7'h00, irq}, 8'h00);
        detectorAbove <= 1'b0;
        cyc(6);
        chk("fallIrq", {7'h00, irq}, 8'h01);
        detectorAbove <= 1'b1;
        cyc(6);
        rd(3'h1, 8'h07, 8'h05, "fallOnly");
        wr(3'h2, 8'h01);
        chk("clrIrq", {7'h00, irq}, 8'h00);
        wr(3'h0, 8'h21);
        detectorAbove <= 1'b0;
        cyc(6);
        detectorAbove <= 1'b1;
        cyc(6);
        rd(3'h1, 8'h07, 8'h06, "riseOnly");
        wr(3'h3, 8'h00);
        chk("maskIrq", {7'h00, irq}, 8'h00);
        wr(3'h2, 8'h03);
        rd(3'h1, 8'h03, 8'h00, "cleared");
        wr(3'h0, 8'h31);
        detectorAbove <= 1'b0;
        cyc(6);
        detectorAbove <= 1'b1;
        cyc(6);
        rd(3'h1, 8'h07, 8'h07, "bothEdges");
        $display("detector tests done");
        wr(3'h0, 8'h40);
        stopMode <= 1'b1;
        cyc(3);
        chk("refOff", {7'h00, referenceOff}, 8'h01);
        stopMode <= 1'b0;
        cyc(3);
        chk("refOn", {7'h00, referenceOff}, 8'h00);
        wr(3'h5, 8'hff);
        rd(3'h5, 8'hff, 8'h00, "unmapped");
        rd(3'h2, 8'hff, 8'h00, "clearRd");
        $display("register tests done");
        final_report();
    end
endmodule : tb
`default_nettype wire
